//--- rtl/htwc_top.sv
/*
 Holdover tuning word control: loop/hold selection, averaging, clipping.
 Assumes loop filter samples and reference status come from CLK_IN logic;
 the holdover pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "htwc_params.svh"
module htwc_top
   import htwc_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic SAMPLE_VALID_IN,
   input wire logic [`HTWC_WORD_W-1:0] SAMPLE_IN,
   input wire logic AVG_ENABLE_IN,
   input wire logic AVG_SELECT_IN,
   input wire logic [`HTWC_Y_W-1:0] AVG_Y_IN,
   input wire logic USE_AVERAGE_IN,
   input wire logic AUTO_HOLD_IN,
   input wire logic HOLDOVER_PIN_IN,
   input wire logic REFA_OK_IN,
   input wire logic REFB_OK_IN,
   input wire logic [`HTWC_T_W-1:0] VALID_T_IN,
   input wire logic LIMIT_WRITE_IN,
   input wire logic [`HTWC_WORD_W-1:0] UPPER_IN,
   input wire logic [`HTWC_WORD_W-1:0] LOWER_IN,
   output logic HOLDOVER_PIN_OUT,
   output logic HOLDOVER_PIN_OE_OUT,
   output logic [1:0] ACTIVE_REF_OUT,
   output logic WORD_VALID_OUT,
   output logic [`HTWC_WORD_W-1:0] FREQUENCY_TUNING_WORD_OUT,
   output logic [`HTWC_WORD_W-1:0] TRACE_OUT
);
   typedef struct packed {
      logic pin_s1;
      logic pin_s2;
      logic hold;
      htwc_ref_e ref_sel;
      logic [32:0] tmr_a;
      logic [32:0] tmr_b;
      htwc_word_t hold_word;
      htwc_word_t last_word;
      htwc_word_t upper;
      htwc_word_t lower;
      logic word_valid;
      htwc_word_t tune_word;
      htwc_word_t trace;
      logic oe;
   } htwc_top_s;
   htwc_top_s r, next_r;
   htwc_avg_if avg_bus();
   logic [32:0] t_len;
   logic a_ok, b_ok, hold_req;
   htwc_word_t raw, clip;

   // ------------------------------------------------------------
   // Averager
   // ------------------------------------------------------------
   assign avg_bus.sample_valid = SAMPLE_VALID_IN & AVG_ENABLE_IN;
   assign avg_bus.sample = SAMPLE_IN;
   assign avg_bus.avg_en = AVG_SELECT_IN;
   assign avg_bus.y_sel = AVG_Y_IN;
   htwc_averager u_avg (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .bus(avg_bus.avg)
   );

   // ------------------------------------------------------------
   // Control and datapath
   // ------------------------------------------------------------
   // Timer length (2^(T+1)-1) sample periods, counted on sample pulses
   always_comb
   begin
      next_r = r;
      t_len = (33'h0_0000_0002 << VALID_T_IN) - 33'h0_0000_0001;
      // Two flops before anything reads the asynchronous pin
      next_r.pin_s1 = HOLDOVER_PIN_IN;
      next_r.pin_s2 = r.pin_s1;
      // Pin direction follows the mode, registered like every output
      next_r.oe = AUTO_HOLD_IN;
      // Validation timers restart whenever the reference is bad
      if (!REFA_OK_IN)
         next_r.tmr_a = '0;
      else if (SAMPLE_VALID_IN && r.tmr_a < t_len)
         next_r.tmr_a = r.tmr_a + 33'h0_0000_0001;
      if (!REFB_OK_IN)
         next_r.tmr_b = '0;
      else if (SAMPLE_VALID_IN && r.tmr_b < t_len)
         next_r.tmr_b = r.tmr_b + 33'h0_0000_0001;
      a_ok = REFA_OK_IN && r.tmr_a >= t_len;
      b_ok = REFB_OK_IN && r.tmr_b >= t_len;
      // Auto mode holds only while neither reference is valid
      if (AUTO_HOLD_IN)
      begin
         if (r.ref_sel == HTWC_REF_A && a_ok)
            hold_req = 1'b0;
         else if (r.ref_sel == HTWC_REF_B && b_ok)
            hold_req = 1'b0;
         else
            hold_req = 1'b1;
         if (hold_req && a_ok)
         begin
            next_r.ref_sel = HTWC_REF_A;
            hold_req = 1'b0;
         end
         else if (hold_req && b_ok)
         begin
            next_r.ref_sel = HTWC_REF_B;
            hold_req = 1'b0;
         end
      end
      else
         hold_req = r.pin_s2;
      next_r.hold = hold_req;
      // Capture hold word on entry only
      if (hold_req && !r.hold)
         next_r.hold_word = USE_AVERAGE_IN ?
            avg_bus.hold_word : r.last_word;
      // Loop word, or static word while holding; exit resumes from it
      raw = hold_req ? next_r.hold_word : SAMPLE_IN;
      // With crossed limits, words above upper take upper and all others take lower, so a bad band stays bounded
      if (raw > r.upper)
         clip = r.upper;
      else if (raw < r.lower)
         clip = r.lower;
      else
         clip = raw;
      // Held word is re-applied every cycle of holdover
      next_r.word_valid = SAMPLE_VALID_IN || hold_req;
      if (SAMPLE_VALID_IN || hold_req)
         next_r.tune_word = clip;
      // Last valid word tracks loop words only, never the held one
      if (SAMPLE_VALID_IN && !hold_req)
         next_r.last_word = clip;
      // Trace shows every averager result, pass or block
      if (avg_bus.out_valid)
         next_r.trace = avg_bus.out_word;
      if (LIMIT_WRITE_IN)
      begin
         next_r.upper = UPPER_IN;
         next_r.lower = LOWER_IN;
      end
   end

   // State register; limits reset to half rate and zero
   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         r <= '0;
         r.ref_sel <= HTWC_REF_A;
         r.upper <= `HTWC_UPPER_RST;
         r.lower <= `HTWC_LOWER_RST;
      end
      else
         r <= next_r;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Pin driven only in automatic mode
   assign HOLDOVER_PIN_OUT = r.hold;
   assign HOLDOVER_PIN_OE_OUT = r.oe;
   assign ACTIVE_REF_OUT = r.ref_sel;
   assign WORD_VALID_OUT = r.word_valid;
   assign FREQUENCY_TUNING_WORD_OUT = r.tune_word;
   assign TRACE_OUT = r.trace;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // Block counter is 17 bits and timers 33; wider settings overflow
   if (`HTWC_Y_W > 4 || `HTWC_T_W > 5)
   begin : g_width_chk
      $error("setting width exceeds counter width");
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Word never leaves the band it was clipped against while upper is not below lower
   clip_band_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      r.word_valid && $past(r.upper >= r.lower)
      |-> r.tune_word <= $past(r.upper) && r.tune_word >= $past(r.lower))
      else $error("word outside limits");
   // Hold word steady while holding
   hold_steady_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      r.hold && $past(r.hold) |-> $stable(r.hold_word))
      else $error("hold word changed");
   // Manual mode follows synchronised pin one cycle later
   manual_pin_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      !AUTO_HOLD_IN ##1 !$past(AUTO_HOLD_IN) |-> r.hold == $past(r.pin_s2))
      else $error("manual hold mismatch");
   // Passthrough output equals the sample
   pass_thru_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      SAMPLE_VALID_IN && AVG_ENABLE_IN && !AVG_SELECT_IN
      |=> avg_bus.out_valid && avg_bus.out_word == $past(SAMPLE_IN))
      else $error("passthrough wrong");
   // Entry captures the word of the selected source
   hold_entry_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      r.hold && !$past(r.hold) |-> r.hold_word ==
         $past(USE_AVERAGE_IN ? avg_bus.hold_word : r.last_word))
      else $error("hold entry word wrong");
   // Synthesizer is fed every cycle of holdover
   hold_valid_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      r.hold |-> r.word_valid)
      else $error("held word not applied");
   // Limits load as a pair on the write strobe
   limit_load_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      LIMIT_WRITE_IN
      |=> r.upper == $past(UPPER_IN) && r.lower == $past(LOWER_IN))
      else $error("limit load wrong");
   // A bad reference A restarts its validation timer
   timer_clear_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      !REFA_OK_IN |=> r.tmr_a == 33'h0_0000_0000)
      else $error("timer not restarted");
   // Trace takes each averager result one cycle later
   trace_follow_a: assert property (@(posedge CLK_IN)
      disable iff (RST_IN)
      avg_bus.out_valid |=> r.trace == $past(avg_bus.out_word))
      else $error("trace not updated");
endmodule : htwc_top
`default_nettype wire

//--- inc/htwc_params.svh
/*
 Constants of the holdover tuning word control block.
 Assumes inclusion by bare name from the package and design files.
*/
// How it works
// - Holdover replaces loop word with held word
// - Background accumulation of up to 65,000 samples; Y of 15 gives 65,536
// - Select averaged or last valid hold word
// - Manual exit resumes loop from held word
// - Auto exit follows first valid reference
// - Averager observes loop samples when enabled
// - Averager output feeds trace and holdover
// - Default mode passes samples unchanged
// - Average blocks of 2^(Y+1) samples
// - Two-stage pipeline, last stage used
// - Pipeline delay is one block period
// - Clip words to 48-bit upper/lower limits
// - Reset limits: half rate and zero
// - Mode bit: 0 manual pin, 1 automatic
// - Validation timer (2^(T+1)-1) sample periods
`ifndef HTWC_PARAMS_SVH
`define HTWC_PARAMS_SVH
`define HTWC_WORD_W 48
`define HTWC_SUM_W 65
`define HTWC_Y_W 4
`define HTWC_T_W 5
`define HTWC_UPPER_RST 48'h8000_0000_0000
`define HTWC_LOWER_RST 48'h0000_0000_0000
`define HTWC_MAX_SAMPLES 65000
`endif

//--- inc/htwc_pkg.sv
/*
 Types of the holdover tuning word control block.
 Assumes the constants header on the include path.
*/
`include "htwc_params.svh"
package htwc_pkg;
   typedef logic [`HTWC_WORD_W-1:0] htwc_word_t;
   typedef enum logic [1:0] {HTWC_REF_NONE, HTWC_REF_A, HTWC_REF_B} htwc_ref_e;
endpackage : htwc_pkg

//--- inc/htwc_avg_if.sv
/*
 Interface between top and averager: sample stream in, averages out.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
`include "htwc_params.svh"
interface htwc_avg_if;
   import htwc_pkg::*;
   logic sample_valid;
   htwc_word_t sample;
   logic avg_en;
   logic [`HTWC_Y_W-1:0] y_sel;
   logic out_valid;
   htwc_word_t out_word;
   htwc_word_t hold_word;
   modport top (output sample_valid, sample, avg_en, y_sel,
      input out_valid, out_word, hold_word);
   modport avg (input sample_valid, sample, avg_en, y_sel,
      output out_valid, out_word, hold_word);
endinterface : htwc_avg_if
`default_nettype wire

//--- rtl/htwc_averager.sv
/*
 Sampler and averager with two-stage hold pipeline.
 Assumes samples arrive as one-cycle valid pulses on CLK_IN.
*/
`timescale 1ns/1ns
`default_nettype none
`include "htwc_params.svh"
module htwc_averager
   import htwc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   htwc_avg_if.avg bus
);
   typedef struct packed {
      logic [`HTWC_SUM_W-1:0] sum;
      logic [16:0] cnt;
      logic out_valid;
      htwc_word_t out_word;
      htwc_word_t stage1;
      htwc_word_t stage2;
   } htwc_avg_s;
   htwc_avg_s r, next_r;
   logic [16:0] blk_len;
   logic [`HTWC_SUM_W-1:0] acc;
   logic [4:0] shamt;
   // ------------------------------------------------------------
   // Block accumulate
   // ------------------------------------------------------------
   // Block length 2^(Y+1); Y above 14 would exceed the sample ceiling
   always_comb
   begin
      next_r = r;
      blk_len = 17'h0_0002 << bus.y_sel;
      acc = r.sum + {{(`HTWC_SUM_W-`HTWC_WORD_W){1'b0}}, bus.sample};
      shamt = {1'b0, bus.y_sel} + 5'h01; // Five bits: Y of 15 shifts by 16
      next_r.out_valid = 1'b0;
      if (bus.sample_valid)
      begin
         if (!bus.avg_en)
         begin
            next_r.out_valid = 1'b1;
            next_r.out_word = bus.sample;
            next_r.stage1 = bus.sample;
            next_r.stage2 = r.stage1;
            next_r.sum = '0;
            next_r.cnt = '0;
         end
         else if (r.cnt + 17'h0_0001 >= blk_len)
         begin
            next_r.out_word = htwc_word_t'(acc >> shamt);
            next_r.out_valid = 1'b1;
            next_r.stage1 = htwc_word_t'(acc >> shamt);
            next_r.stage2 = r.stage1;
            next_r.sum = '0;
            next_r.cnt = '0;
         end
         else
         begin
            next_r.sum = acc;
            next_r.cnt = r.cnt + 17'h0_0001;
         end
      end
   end
   // State register
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         r <= '0;
      else
         r <= next_r;
   end
   assign bus.out_valid = r.out_valid;
   assign bus.out_word = r.out_word;
   assign bus.hold_word = r.stage2;
   // Stage two takes stage one on each completed block
   pipe_shift_a: assert property (@(posedge clk_in)
      disable iff (rst_in)
      r.out_valid |-> r.stage2 == $past(r.stage1))
      else $error("pipeline shift wrong");
endmodule : htwc_averager
`default_nettype wire

//--- tb/htwc_synth_model.sv
/*
 Synthesizer core model: keeps the tuning word it was last handed.
 Assumes words arrive with their valid flag on the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
`include "htwc_params.svh"
module htwc_synth_model
   import htwc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic word_valid_in,
   input wire logic [`HTWC_WORD_W-1:0] word_in,
   output logic [`HTWC_WORD_W-1:0] last_word_out,
   output logic [15:0] count_out
);
   // Latch each applied word; in hold it is re-applied every cycle
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         last_word_out <= 48'h0000_0000_0000;
         count_out <= 16'h0000;
      end
      else if (word_valid_in)
      begin
         last_word_out <= word_in;
         count_out <= count_out + 16'h0001;
      end
   end
endmodule : htwc_synth_model
`default_nettype wire

//--- tb/tb_htwc_top.sv
/*
 Self-checking bench: averaging, holdover, pass-through and clipping.
 Assumes package, interface and design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "htwc_params.svh"
module tb_htwc_top
   import htwc_pkg::*;
;
   localparam htwc_word_t ONE = 48'h0000_0000_0001;
   logic clk = 1'b0, rst = 1'b1, sv = 1'b0, aen = 1'b1, asel = 1'b1;
   logic usea = 1'b1, auto = 1'b0, pin = 1'b0, refa = 1'b1, refb = 1'b1;
   logic lw = 1'b0, hold, oe, wv;
   logic [3:0] y = 4'h0;
   logic [4:0] t = 5'h00; // Default interval spans a divided cycle
   logic [1:0] aref;
   logic [15:0] cnt, c0;
   htwc_word_t smp = 48'h0000_0000_0000, up = 48'h0000_0000_0000;
   htwc_word_t lo = 48'h0000_0000_0000, tune, trace, last;
   int miscompares = 0;
   int checks_done = 0;

   // ------------------------------------------------------------
   // Clock, design and far-side model
   // ------------------------------------------------------------
   always #10 clk = ~clk;

   htwc_top i_dut (.CLK_IN(clk), .RST_IN(rst), .SAMPLE_VALID_IN(sv),
      .SAMPLE_IN(smp), .AVG_ENABLE_IN(aen), .AVG_SELECT_IN(asel),
      .AVG_Y_IN(y), .USE_AVERAGE_IN(usea), .AUTO_HOLD_IN(auto),
      .HOLDOVER_PIN_IN(pin), .REFA_OK_IN(refa), .REFB_OK_IN(refb),
      .VALID_T_IN(t), .LIMIT_WRITE_IN(lw), .UPPER_IN(up), .LOWER_IN(lo),
      .HOLDOVER_PIN_OUT(hold), .HOLDOVER_PIN_OE_OUT(oe),
      .ACTIVE_REF_OUT(aref), .WORD_VALID_OUT(wv),
      .FREQUENCY_TUNING_WORD_OUT(tune), .TRACE_OUT(trace));

   htwc_synth_model i_core (.clk_in(clk), .rst_in(rst), .word_valid_in(wv),
      .word_in(tune), .last_word_out(last), .count_out(cnt));

   // Compare and count; a mismatch is reported at once
   task automatic chk(input htwc_word_t seen, input htwc_word_t exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk) #1;
   endtask : cyc

   // One sample pulse; data goes stale after it so no stale match passes
   task automatic send(input htwc_word_t x);
      sv = 1'b1;
      smp = x;
      cyc(1);
      sv = 1'b0;
      smp = ~x;
      cyc(1);
   endtask : send

   task automatic limits(input htwc_word_t u, input htwc_word_t l);
      up = u;
      lo = l;
      lw = 1'b1;
      cyc(1);
      lw = 1'b0;
   endtask : limits

   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial
   begin
      #200000;
      miscompares++;
      finish_test();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      cyc(1);
      chk(48'(aref), ONE);
      chk(48'(oe), 48'h0000_0000_0000);
      // Blocks of two, then four, with truncating shift
      send(48'h0000_0000_0003);
      send(48'h0000_0000_0004);
      chk(last, 48'h0000_0000_0004);
      chk(trace, 48'h0000_0000_0003);
      y = 4'h1;
      send(48'h0000_0000_0001);
      send(48'h0000_0000_0002);
      send(48'h0000_0000_0003);
      send(48'h0000_0000_0005);
      chk(trace, 48'h0000_0000_0002);
      // Three blocks; hold takes the one before the newest
      y = 4'h0;
      for (int k = 1; k < 4; k++)
      begin
         send(48'(k) << 8);
         send(48'(k) << 8);
      end
      pin = 1'b1;
      cyc(6);
      chk(48'(hold), ONE);
      chk(last, 48'h0000_0000_0200);
      pin = 1'b0;
      cyc(6);
      chk(last, 48'h0000_0000_0200);
      send(48'h0000_0000_0777);
      chk(last, 48'h0000_0000_0777);
      // Last valid word as hold source
      usea = 1'b0;
      pin = 1'b1;
      cyc(6);
      chk(last, 48'h0000_0000_0777);
      pin = 1'b0;
      cyc(6);
      // Pass-through, default and programmed clipping
      asel = 1'b0;
      send(48'h1234_5678_9abc);
      chk(last, 48'h1234_5678_9abc);
      chk(trace, 48'h1234_5678_9abc);
      // Averager off: trace keeps its word, core still fed once
      aen = 1'b0;
      c0 = cnt;
      send(48'h0000_0000_0abc);
      chk(trace, 48'h1234_5678_9abc);
      chk(48'(cnt - c0), ONE);
      aen = 1'b1;
      send(48'hffff_0000_0000);
      chk(last, `HTWC_UPPER_RST);
      limits(48'h0000_0100_0000, 48'h0000_0010_0000);
      send(48'h0000_0200_0000);
      chk(last, up);
      send(48'h0000_0001_0000);
      chk(last, lo);
      send(48'h0000_0050_0000);
      chk(last, 48'h0000_0050_0000);
      // Automatic mode: both fail, then B returns and is taken
      auto = 1'b1;
      refa = 1'b0; // A left steadily down, no chatter
      refb = 1'b0;
      cyc(6);
      chk(48'(oe), ONE);
      chk(48'(hold), ONE);
      refb = 1'b1;
      cyc(2);
      chk(48'(hold), ONE);
      repeat (4) send(48'h0000_0060_0000);
      cyc(3);
      chk(48'(aref), 48'h0000_0000_0002);
      chk(48'(hold), 48'h0000_0000_0000);
      finish_test();
   end
endmodule : tb_htwc_top
`default_nettype wire
